// >>> pe_parity_buffer.sv
// Function
// - data taken at edge n drives the error output at edge n+2.
// - once driven low, the error output stays low two cycles or until reset.
// - link_rst_n low clears the link-domain outputs and releases the error output without a clock; error_event and error_count clear on sys_rst.
// - inputs sampled on the rising edge of the link clock.
// - error output follows the registered data output by one cycle.
`timescale 1ns/1ps
`default_nettype none
module pe_parity_buffer
   import pe_pkg::*;
#(
   parameter int DATA_W = PE_DATA_W,
   parameter logic [PE_DATA_W-1:0] PARITY_MASK = PE_PARITY_MASK
)
(
   // system clock domain
   input wire logic clk,
   input wire logic sys_rst,
   // link clock domain, driven by the controller
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic parity_bit_in,
   // registered data outputs
   output logic [DATA_W-1:0] registered_output,
   // open-drain error pin, output and enable
   output logic parity_error_n_out,
   output logic parity_error_n_oe_n,
   // error events in the system domain
   output logic error_event,
   output logic [PE_COUNT_W-1:0] error_count
);
   pe_evt_if evt ();

   // capture pipeline
   logic [DATA_W-1:0] in_reg;
   logic [DATA_W-1:0] in_next;
   logic [DATA_W-1:0] out_reg;
   logic [DATA_W-1:0] out_next;
   // parity compare
   logic mismatch_reg;
   logic mismatch_next;
   // error state
   pe_err_state_type state_reg;
   pe_err_state_type state_next;
   // error pin
   logic oe_n_reg;
   logic oe_n_next;
   logic drive_reg;
   logic drive_next;
   // event toggle toward the system domain
   logic toggle_reg;
   logic toggle_next;

   function automatic logic masked_parity(input logic [DATA_W-1:0] d);
      masked_parity = ^(d & PARITY_MASK[DATA_W-1:0]);
   endfunction

   // capture pipeline
   always_comb
   begin
      // capture at the rising link edge n
      in_next = data_in;
      // data shown one edge later so the error trails it by one
      out_next = in_reg;
   end

   // async clear; zeroed pipeline gives no false error while inputs stay low
   always_ff @(posedge link_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         in_reg <= '0;
         out_reg <= '0;
      end
      else
      begin
         in_reg <= in_next;
         out_reg <= out_next;
      end
   end

   // parity compare
   always_comb
   begin
      // parity arrives one edge after its data
      mismatch_next = parity_bit_in ^ masked_parity(in_reg);
   end

   always_ff @(posedge link_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         mismatch_reg <= 1'b0;
      end
      else
      begin
         mismatch_reg <= mismatch_next;
      end
   end

   // error state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         PE_ERR_IDLE:
         begin
            if (mismatch_reg)
            begin
               state_next = PE_ERR_FLAG;
            end
         end
         PE_ERR_FLAG:
         begin
            // a fresh error restarts the two-cycle hold
            state_next = mismatch_reg ? PE_ERR_FLAG : PE_ERR_HOLD;
         end
         PE_ERR_HOLD:
         begin
            state_next = mismatch_reg ? PE_ERR_FLAG : PE_ERR_IDLE;
         end
         default:
         begin
            state_next = PE_ERR_IDLE;
         end
      endcase
   end

   // reset drops any latched error at once
   always_ff @(posedge link_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         state_reg <= PE_ERR_RST;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // error pin; taken from the next state so the pin stays a flop
   always_comb
   begin
      oe_n_next = (state_next == PE_ERR_IDLE);
      // open drain only ever pulls low
      drive_next = 1'b0;
   end

   always_ff @(posedge link_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         oe_n_reg <= 1'b1;
         drive_reg <= 1'b0;
      end
      else
      begin
         oe_n_reg <= oe_n_next;
         drive_reg <= drive_next;
      end
   end

   // event toggle
   always_comb
   begin
      // one toggle per assertion; closer than one system cycle may merge
      toggle_next = toggle_reg;
      if ((state_reg == PE_ERR_IDLE) && mismatch_reg)
      begin
         toggle_next = ~toggle_reg;
      end
   end

   // a toggle, not a pulse, so a slow system clock cannot miss it
   always_ff @(posedge link_clk or negedge link_rst_n)
   begin
      if (!link_rst_n)
      begin
         toggle_reg <= 1'b0;
      end
      else
      begin
         toggle_reg <= toggle_next;
      end
   end

   assign evt.err_toggle = toggle_reg;
   assign registered_output = out_reg;
   assign parity_error_n_out = drive_reg;
   assign parity_error_n_oe_n = oe_n_reg;

   pe_evt_sync u_evt_sync
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .evt(evt.dst),
      .event_pulse(error_event),
      .event_count(error_count)
   );
endmodule // pe_parity_buffer
`default_nettype wire

// >>> pe_pkg.sv
`default_nettype none
package pe_pkg;
   // data path width and parity coverage
   localparam int PE_DATA_W = 28;
   localparam logic [27:0] PE_PARITY_MASK = 28'h0FFF_FFFF;
   // width of the event counter seen by system logic
   localparam int PE_COUNT_W = 16;
   localparam logic [15:0] PE_COUNT_RST = 16'h0000;
   // receiver timing, owed by the controller; times in ns
   localparam int PE_RECEIVER_ACTIVATION_TIME_NS = 10;
   localparam int PE_RECEIVER_DEACTIVATION_TIME_NS = 15;
   localparam int PE_CLK_PERIOD_NS = 100;
   // least times round up, never below one cycle
   localparam int PE_ACT_CYCLES_RAW =
      (PE_RECEIVER_ACTIVATION_TIME_NS + PE_CLK_PERIOD_NS - 1) / PE_CLK_PERIOD_NS;
   localparam int PE_ACT_CYCLES = (PE_ACT_CYCLES_RAW < 1) ? 1 : PE_ACT_CYCLES_RAW;
   localparam int PE_INACT_CYCLES_RAW =
      (PE_RECEIVER_DEACTIVATION_TIME_NS + PE_CLK_PERIOD_NS - 1) / PE_CLK_PERIOD_NS;
   localparam int PE_INACT_CYCLES = (PE_INACT_CYCLES_RAW < 1) ? 1 : PE_INACT_CYCLES_RAW;
   // error output state, gray along idle -> flag -> hold
   typedef enum logic [1:0]
   {
      PE_ERR_IDLE = 2'b00,
      PE_ERR_FLAG = 2'b01,
      PE_ERR_HOLD = 2'b11
   } pe_err_state_type;
   localparam pe_err_state_type PE_ERR_RST = PE_ERR_IDLE;
endpackage
`default_nettype wire

// >>> pe_evt_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pe_evt_if;
   // toggles once per error assertion, link clock domain
   logic err_toggle;
   modport src
   (
      output err_toggle
   );
   modport dst
   (
      input err_toggle
   );
endinterface
`default_nettype wire

// >>> pe_evt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pe_evt_sync
   import pe_pkg::*;
(
   // system clock
   input wire logic clk,
   input wire logic sys_rst,
   // toggle from the link domain
   pe_evt_if.dst evt,
   // event seen in system domain
   output logic event_pulse,
   output logic [PE_COUNT_W-1:0] event_count
);
   logic sync1_reg;
   logic sync2_reg;
   logic last_reg;
   logic pulse_reg;
   logic [PE_COUNT_W-1:0] count_reg;
   logic sync1_next;
   logic sync2_next;
   logic last_next;
   logic pulse_next;
   logic [PE_COUNT_W-1:0] count_next;

   // only the second stage is looked at beyond the first
   always_comb
   begin
      sync1_next = evt.err_toggle;
      sync2_next = sync1_reg;
      last_next = sync2_reg;
      pulse_next = sync2_reg ^ last_reg;
      count_next = count_reg;
      if (sync2_reg ^ last_reg)
      begin
         count_next = count_reg + PE_COUNT_W'(1);
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         last_reg <= 1'b0;
         pulse_reg <= 1'b0;
         count_reg <= PE_COUNT_RST;
      end
      else
      begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         last_reg <= last_next;
         pulse_reg <= pulse_next;
         count_reg <= count_next;
      end
   end

   assign event_pulse = pulse_reg;
   assign event_count = count_reg;
endmodule // pe_evt_sync
`default_nettype wire

// >>> pe_parity_buffer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pe_parity_buffer_chk
#(parameter int DATA_W = pe_pkg::PE_DATA_W)
(
   // system domain
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic error_event,
   input wire logic [pe_pkg::PE_COUNT_W-1:0] error_count,
   // link domain
   input wire logic link_clk,
   input wire logic link_rst_n,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic parity_bit_in,
   input wire logic [DATA_W-1:0] registered_output,
   input wire logic parity_error_n_out,
   input wire logic parity_error_n_oe_n
);
   import pe_pkg::*;
   logic par_reg, par_next, mism;
   always_comb par_next = ^data_in;
   always_ff @(posedge link_clk) par_reg <= par_next;
   assign mism = par_reg ^ parity_bit_in;
   AST_ERR_LAT: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      mism |-> ##2 !parity_error_n_oe_n) else $error("error late");
   AST_ERR_CAUSE: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $fell(parity_error_n_oe_n) |-> $past(mism, 2)) else $error("false error");
   AST_ERR_HOLD: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      $fell(parity_error_n_oe_n) |=> !parity_error_n_oe_n) else $error("hold short");
   AST_REG_OUT: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      registered_output == $past(data_in, 2)) else $error("data out");
   AST_RST_CLR: assert property (@(posedge clk) disable iff (sys_rst)
      !link_rst_n |-> registered_output == '0 && parity_error_n_oe_n) else $error("rst");
   AST_EVT_CNT: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(error_event) |-> error_count == $past(error_count) + 1'b1 ##1 !error_event)
      else $error("event");
   cover property (@(posedge link_clk) $fell(parity_error_n_oe_n));
   cover property (@(posedge link_clk) mism ##1 mism);
   cover property (@(posedge clk) $rose(error_event));
endmodule // pe_parity_buffer_chk
bind pe_parity_buffer pe_parity_buffer_chk #(.DATA_W(DATA_W)) u_chk (.clk(clk),
   .sys_rst(sys_rst), .error_event(error_event), .error_count(error_count),
   .link_clk(link_clk), .link_rst_n(link_rst_n), .data_in(data_in),
   .parity_bit_in(parity_bit_in), .registered_output(registered_output),
   .parity_error_n_out(parity_error_n_out), .parity_error_n_oe_n(parity_error_n_oe_n));
`default_nettype wire

// >>> pe_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module pe_ctrl_model
(
   // link side
   output logic link_clk,
   output logic [pe_pkg::PE_DATA_W-1:0] data_in,
   output logic parity_bit_in,
   // bench side
   input wire logic link_rst_n,
   input wire logic bad
);
   import pe_pkg::*;
   logic rdy;
   initial {link_clk, data_in, parity_bit_in, rdy} = '0;
   // free running, receivers need a stable clock across reset
   always #15 link_clk = ~link_clk;
   always @(posedge link_clk)
   begin
      rdy <= link_rst_n;
      // driven, never floating; low one edge past release
      if (!rdy)
      begin
         data_in <= '0;
         parity_bit_in <= 1'b0;
      end
      else
      begin
         data_in <= {data_in[PE_DATA_W-2:0], ~data_in[PE_DATA_W-1]};
         parity_bit_in <= ^data_in ^ bad;
      end
   end
endmodule // pe_ctrl_model
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin err_total++; \
   $display("mismatch %0t %s", $time, m); end end
module tb;
   import pe_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic link_rst_n = 1'b0;
   logic bad = 1'b0;
   logic link_clk, par, pout, oe_n, evt;
   logic [PE_DATA_W-1:0] din, rout;
   logic [PE_COUNT_W-1:0] cnt;
   int err_total = 0;
   int num_checks = 0;
   int n_evt = 0;
   // open-drain pin with pull-up
   wire logic pin = oe_n ? 1'b1 : pout;
   always #50 clk = ~clk;
   // pulses seen on the system side
   always @(posedge clk)
   begin
      if (evt === 1'b1)
      begin
         n_evt++;
      end
   end
   pe_ctrl_model u_ctrl (.link_clk(link_clk), .data_in(din), .parity_bit_in(par),
      .link_rst_n(link_rst_n), .bad(bad));
   pe_parity_buffer DUT (.clk(clk), .sys_rst(sys_rst), .link_clk(link_clk),
      .link_rst_n(link_rst_n), .data_in(din), .parity_bit_in(par),
      .registered_output(rout), .parity_error_n_out(pout),
      .parity_error_n_oe_n(oe_n), .error_event(evt), .error_count(cnt));
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic t_reset;
      repeat (3) @(negedge clk);
      `CHK(rout, '0, "rst data")
      `CHK(pin, 1'b1, "rst pin")
      sys_rst = 1'b0;
      link_rst_n = 1'b1;
      repeat (20) @(negedge clk);
      `CHK(cnt, 16'h0000, "quiet count")
      `CHK(pin, 1'b1, "quiet pin")
      $display("t_reset done");
   endtask
   task automatic t_error(int k);
      logic [PE_COUNT_W-1:0] c0;
      int e0;
      c0 = cnt;
      e0 = n_evt;
      repeat (k)
      begin
         bad = 1'b1;
         @(negedge clk);
         bad = 1'b0;
         `CHK(pin, 1'b0, "no error")
         repeat (12) @(negedge clk);
         `CHK(pin, 1'b1, "stuck")
      end
      `CHK(cnt, c0 + k[PE_COUNT_W-1:0], "count")
      `CHK(n_evt, e0 + k, "event pulses")
      `CHK(evt, 1'b0, "event stuck")
      $display("t_error done");
   endtask
   task automatic t_midreset;
      bad = 1'b1;
      @(negedge clk);
      `CHK(pin, 1'b0, "no error")
      link_rst_n = 1'b0;
      #1;
      `CHK(pin, 1'b1, "async pin")
      `CHK(rout, '0, "async data")
      @(negedge clk);
      bad = 1'b0;
      @(negedge clk);
      link_rst_n = 1'b1;
      repeat (10) @(negedge clk);
      `CHK(pin, 1'b1, "false error")
      $display("t_midreset done");
   endtask
   initial
   begin
      #50000;
      err_total++;
      $display("mismatch %0t watchdog", $time);
      final_report();
   end
   initial
   begin
      t_reset();
      t_error(1);
      t_error(2);
      t_midreset();
      final_report();
   end
endmodule // tb
`default_nettype wire
